// file: ais_pkg.sv
// Purpose: shared constants and types for the analog input select block
// Assumes: classic wishbone, 32-bit data, registers in the low 16 bits
// Notes:   offsets are byte addresses, one aligned word per register

package ais_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] AIS_OFF_CH123 = 8'h00;
  localparam logic [7:0] AIS_OFF_CH0   = 8'h04;
  localparam logic [7:0] AIS_OFF_SCAN  = 8'h08;
  localparam logic [7:0] AIS_OFF_PIN   = 8'h0c;
  localparam logic [7:0] AIS_OFF_CTRL  = 8'h10;
  localparam logic [7:0] AIS_OFF_STAT  = 8'h14;

  // ==========================================================
  // values after reset
  localparam logic [15:0] AIS_CH123_RST = 16'h0000;
  localparam logic [15:0] AIS_CH0_RST   = 16'h0000;
  localparam logic [12:0] AIS_SCAN_RST  = 13'h0000;
  localparam logic [12:0] AIS_PIN_RST   = 13'h0000;
  localparam logic [3:0]  AIS_CTRL_RST  = 4'h0;
  localparam logic [3:0]  AIS_PTR_RST   = 4'h0;

  // ==========================================================
  // implemented bits of each register
  localparam logic [15:0] AIS_CH123_MASK = 16'h0707;
  localparam logic [15:0] AIS_CH0_MASK   = 16'h9f9f;
  localparam logic [15:0] AIS_INPUT_MASK = 16'h1fff;
  localparam logic [15:0] AIS_CTRL_MASK  = 16'h000f;

  // ==========================================================
  // field positions
  localparam int AIS_C123_POS_A = 0;
  localparam int AIS_C123_NEG_A = 1;
  localparam int AIS_C123_POS_B = 8;
  localparam int AIS_C123_NEG_B = 9;
  localparam int AIS_C0_POS_A   = 0;
  localparam int AIS_C0_NEG_A   = 7;
  localparam int AIS_C0_POS_B   = 8;
  localparam int AIS_C0_NEG_B   = 15;
  localparam int AIS_CTRL_RES   = 0;
  localparam int AIS_CTRL_SCAN  = 1;
  localparam int AIS_CTRL_ALT   = 2;
  localparam int AIS_CTRL_DIS   = 3;
  localparam int AIS_STAT_PHASE = 0;
  localparam int AIS_STAT_PTR   = 4;
  localparam int AIS_STAT_POS   = 8;

  // ==========================================================
  // input numbering and negative select codes
  localparam int         AIS_NUM_INPUTS = 13;
  localparam logic [4:0] AIS_LAST_INPUT = 5'h0c;
  localparam logic [1:0] AIS_NEG_VREF   = 2'h0;

  typedef enum logic {
    AIS_PH_A = 1'b0,
    AIS_PH_B = 1'b1
  } ais_phase_t;

endpackage

// file: ais_input_select.sv
// Purpose: input routing configuration for a four channel sample/convert unit
// Assumes: sample_done is a one-cycle pulse from converter logic on mclk
// Notes:   all routing outputs lag register state by one clock
//          map: 0x00 ch1-3 select, 0x04 ch0 select, 0x08 scan mask, 0x0c pin mode,
//          0x10 control, 0x14 status (read only), anything else reads zero
//          control bits: 0 twelve-bit, 1 scan enable, 2 alternate, 3 disable
//          status bits: 0 phase b, 7:4 scan pointer, 12:8 ch0 positive input
//
// Behaviour
// - phase B ch1-3 negative: 11 -> inputs 9-11, 10 -> inputs 6-8, 0x -> neg reference
// - phase A ch1-3 negative uses the same encoding as phase B
// - phase B ch1-3 positive: set -> inputs 3-5, clear -> inputs 0-2
// - phase A ch1-3 positive: set -> inputs 3-5, clear -> inputs 0-2
// - in twelve-bit mode every ch1-3 field is unimplemented and reads zero
// - resolution bit set selects twelve-bit one channel, clear ten-bit four channels
// - phase A ch0 negative bit: set -> input 1, clear -> neg reference
// - phase B ch0 negative bit at bit 15 mirrors bit 7 encoding
// - phase B ch0 positive field selects input equal to its code, 0 to 12
// - phase A ch0 positive field in bits 4-0 uses the same encoding
// - scan mask bit n includes input n in the ch0 scan sequence
// - any mask bit writable; a missing input converts as the neg reference
// - ch0 positive scanning in phase A happens only while scan enable is set
// - alternate mode uses phase A then phase B alternately, else always A
// - pin mode set: digital, port read on, mux to ground; clear: analog
// - all 13 pin mode bits read and write; missing inputs ignore them
// - converter disabled: pin mode bits ignored, all shared pins digital
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.

`timescale 1ns/1ps

module ais_input_select
  import ais_pkg::*;
#(
  parameter logic [12:0] PRESENT_MASK = 13'h1fff
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // converter sequencing
  input  wire logic        sample_done,
  // channel 0 routing
  output logic      [4:0]  ch0_pos_input,
  output logic             ch0_pos_to_vref,
  output logic             ch0_pos_to_avss,
  output logic             ch0_neg_an1,
  // channels 1 to 3 routing
  output logic             ch123_enable,
  output logic             ch123_pos_upper,
  output logic      [1:0]  ch123_neg_sel,
  // mode status
  output logic             sample_phase_b,
  output logic             resolution_12bit,
  output logic      [12:0] pin_digital
);

  // ==========================================================
  // state
  typedef struct packed {
    // software visible registers
    logic [15:0] ch123;
    logic [15:0] ch0;
    logic [12:0] scan;
    logic [12:0] pin;
    logic [3:0]  ctrl;
    // sequencing and bus answer
    ais_phase_t  phase;
    logic [3:0]  scan_ptr;
    logic        ack;
    logic [31:0] rdata;
    // routing outputs, one clock behind the registers
    logic [4:0]  pos_in;
    logic        pos_vref;
    logic        pos_avss;
    logic        neg_an1;
    logic        c123_en;
    logic        c123_upper;
    logic [1:0]  c123_neg;
    logic        ph_b;
    logic        res12;
    logic [12:0] pin_dig;
  } ais_state_t;

  ais_state_t q_reg;
  ais_state_t q_next;

  // ==========================================================
  // helpers

  // first set mask bit at or after start, wrapping; start when mask empty
  function automatic logic [3:0] ais_scan_from(input logic [12:0] mask,
                                               input logic [3:0]  start);
    logic [4:0] s;
    logic [3:0] res;
    logic       found;
    res   = start;
    found = 1'b0;
    for (int i = 0; i < AIS_NUM_INPUTS; i++) begin
      s = 5'({1'b0, start}) + 5'(i);
      if (s >= 5'(AIS_NUM_INPUTS)) begin
        s = s - 5'(AIS_NUM_INPUTS);
      end
      if (!found && mask[s[3:0]]) begin
        res   = s[3:0];
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // byte-lane merge limited to the implemented bits
  function automatic logic [15:0] ais_merge(input logic [15:0] old,
                                            input logic [15:0] data,
                                            input logic [3:0]  sel,
                                            input logic [15:0] impl);
    logic [15:0] m;
    m = {{8{sel[1]}}, {8{sel[0]}}} & impl;
    return (old & ~m) | (data & m);
  endfunction

  // true for an input number that exists on this variant; keeps every
  // per-input index below 13
  function automatic logic ais_input_ok(input logic [4:0] num);
    logic ok;
    ok = 1'b0;
    if (num <= AIS_LAST_INPUT) begin
      ok = PRESENT_MASK[num[3:0]];
    end
    return ok;
  endfunction

  // merge for the 13-bit per-input registers
  function automatic logic [12:0] ais_merge13(input logic [12:0] old,
                                              input logic [15:0] data,
                                              input logic [3:0]  sel);
    logic [15:0] w;
    w = ais_merge({3'h0, old}, data, sel, AIS_INPUT_MASK);
    return w[12:0];
  endfunction

  // next input number, wrapping from the last input back to input 0
  function automatic logic [3:0] ais_wrap_inc(input logic [3:0] num);
    logic [3:0] n;
    n = (num == AIS_LAST_INPUT[3:0]) ? 4'h0 : num + 4'h1;
    return n;
  endfunction

  // read-only status word: phase, scan pointer, ch0 positive input
  function automatic logic [15:0] ais_status(input logic       phase_b,
                                             input logic [3:0] ptr,
                                             input logic [4:0] pos_in);
    logic [15:0] w;
    w                    = 16'h0000;
    w[AIS_STAT_PHASE]    = phase_b;
    w[AIS_STAT_PTR +: 4] = ptr;
    w[AIS_STAT_POS +: 5] = pos_in;
    return w;
  endfunction

  // one phase of the ch1-3 selection as {negative code, positive upper}
  function automatic logic [2:0] ais_c123_pick(input logic [15:0] sel,
                                               input logic        phase_b);
    logic [2:0] f;
    f = 3'h0;
    if (phase_b) begin
      f = {sel[AIS_C123_NEG_B +: 2], sel[AIS_C123_POS_B]};
    end else begin
      f = {sel[AIS_C123_NEG_A +: 2], sel[AIS_C123_POS_A]};
    end
    return f;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic        req;
    logic        commit;
    logic        alt;
    logic        scan_on;
    logic        ph_b;
    logic [3:0]  scan_pos;
    logic [4:0]  pos;
    logic        present;
    logic [12:0] dig;
    logic [15:0] wr;
    logic [15:0] stat;
    logic [3:0]  ptr_inc;

    req      = wb_cyc_i & wb_stb_i;
    commit   = 1'b0;
    alt      = 1'b0;
    scan_on  = 1'b0;
    ph_b     = 1'b0;
    scan_pos = 4'h0;
    pos      = 5'h00;
    present  = 1'b0;
    dig      = 13'h0000;
    wr       = 16'h0000;
    stat     = 16'h0000;
    ptr_inc  = 4'h0;
    q_next   = q_reg;

    // ---- bus: ack one cycle after the request, write at the ack edge
    // writing on the ack edge keeps the write and its answer in one cycle
    q_next.ack = req & ~q_reg.ack;
    commit     = req & q_reg.ack & wb_we_i;

    stat = ais_status(q_reg.ph_b, q_reg.scan_ptr, q_reg.pos_in);

    // read data is captured as the request is taken so it stands beside ack
    if (req && !q_reg.ack) begin
      case (wb_adr_i)
        AIS_OFF_CH123: begin
          // twelve-bit mode hides ch1-3 selection
          q_next.rdata = q_reg.ctrl[AIS_CTRL_RES] ? 32'h0 : {16'h0, q_reg.ch123};
        end
        AIS_OFF_CH0:  q_next.rdata = {16'h0, q_reg.ch0};
        AIS_OFF_SCAN: q_next.rdata = {19'h0, q_reg.scan};
        AIS_OFF_PIN:  q_next.rdata = {19'h0, q_reg.pin};
        AIS_OFF_CTRL: q_next.rdata = {28'h0, q_reg.ctrl};
        AIS_OFF_STAT: q_next.rdata = {16'h0, stat};
        default:      q_next.rdata = 32'h0;
      endcase
    end

    if (commit) begin
      case (wb_adr_i)
        AIS_OFF_CH123: begin
          if (!q_reg.ctrl[AIS_CTRL_RES]) begin
            q_next.ch123 = ais_merge(q_reg.ch123, wb_dat_i[15:0], wb_sel_i,
                                     AIS_CH123_MASK);
          end
        end
        AIS_OFF_CH0: begin
          q_next.ch0 = ais_merge(q_reg.ch0, wb_dat_i[15:0], wb_sel_i, AIS_CH0_MASK);
        end
        AIS_OFF_SCAN: begin
          // every mask bit is writable whatever the variant
          q_next.scan = ais_merge13(q_reg.scan, wb_dat_i[15:0], wb_sel_i);
        end
        AIS_OFF_PIN: begin
          // absent inputs keep what is written but still route as digital
          q_next.pin = ais_merge13(q_reg.pin, wb_dat_i[15:0], wb_sel_i);
        end
        AIS_OFF_CTRL: begin
          wr          = ais_merge({12'h0, q_reg.ctrl}, wb_dat_i[15:0], wb_sel_i,
                                  AIS_CTRL_MASK);
          q_next.ctrl = wr[3:0];
        end
        default: begin
        end
      endcase
    end

    // ---- sample sequencing
    alt     = q_reg.ctrl[AIS_CTRL_ALT];
    scan_on = q_reg.ctrl[AIS_CTRL_SCAN] && (q_reg.scan != 13'h0000);
    ph_b    = alt && (q_reg.phase == AIS_PH_B);
    // keep the pointer on a selected input even after the mask changes
    scan_pos = ais_scan_from(q_reg.scan, q_reg.scan_ptr);

    if (!alt) begin
      q_next.phase = AIS_PH_A;
    end else if (sample_done) begin
      q_next.phase = (q_reg.phase == AIS_PH_A) ? AIS_PH_B : AIS_PH_A;
    end

    // phase B samples use their fixed field, so the pointer waits for phase A
    if (sample_done && scan_on && !ph_b) begin
      ptr_inc = ais_wrap_inc(scan_pos);
      q_next.scan_ptr = ais_scan_from(q_reg.scan, ptr_inc);
    end

    // ---- pin modes: missing inputs and a disabled converter force digital
    if (q_reg.ctrl[AIS_CTRL_DIS]) begin
      dig = 13'h1fff;
    end else begin
      dig = q_reg.pin | ~PRESENT_MASK;
    end
    q_next.pin_dig = dig;

    // ---- channel 0 positive
    if (ph_b) begin
      pos = q_reg.ch0[AIS_C0_POS_B +: 5];
    end else if (scan_on) begin
      pos = {1'b0, scan_pos};
    end else begin
      pos = q_reg.ch0[AIS_C0_POS_A +: 5];
    end
    present         = ais_input_ok(pos);
    q_next.pos_in   = pos;
    q_next.pos_vref = ~present;
    q_next.pos_avss = present & dig[pos[3:0]];

    // ---- channel 0 negative
    q_next.neg_an1 = ph_b ? q_reg.ch0[AIS_C0_NEG_B] : q_reg.ch0[AIS_C0_NEG_A];

    // ---- channels 1 to 3
    q_next.res12   = q_reg.ctrl[AIS_CTRL_RES];
    q_next.c123_en = ~q_reg.ctrl[AIS_CTRL_RES];
    if (q_reg.ctrl[AIS_CTRL_RES]) begin
      q_next.c123_upper = 1'b0;
      q_next.c123_neg   = AIS_NEG_VREF;
    end else begin
      {q_next.c123_neg, q_next.c123_upper} = ais_c123_pick(q_reg.ch123, ph_b);
    end
    q_next.ph_b = ph_b;
  end

  // ==========================================================
  // registers
  // routing fields clear here and refresh on the first edge after reset
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q_reg          <= '0;
      q_reg.ch123    <= AIS_CH123_RST;
      q_reg.ch0      <= AIS_CH0_RST;
      q_reg.scan     <= AIS_SCAN_RST;
      q_reg.pin      <= AIS_PIN_RST;
      q_reg.ctrl     <= AIS_CTRL_RST;
      q_reg.scan_ptr <= AIS_PTR_RST;
      q_reg.phase    <= AIS_PH_A;
    end else begin
      q_reg <= q_next;
    end
  end

  // ==========================================================
  // outputs, all straight from flip-flops
  assign wb_dat_o         = q_reg.rdata;
  assign wb_ack_o         = q_reg.ack;
  assign ch0_pos_input    = q_reg.pos_in;
  assign ch0_pos_to_vref  = q_reg.pos_vref;
  assign ch0_pos_to_avss  = q_reg.pos_avss;
  assign ch0_neg_an1      = q_reg.neg_an1;
  assign ch123_enable     = q_reg.c123_en;
  assign ch123_pos_upper  = q_reg.c123_upper;
  assign ch123_neg_sel    = q_reg.c123_neg;
  assign sample_phase_b   = q_reg.ph_b;
  assign resolution_12bit = q_reg.res12;
  assign pin_digital      = q_reg.pin_dig;

endmodule // ais_input_select

// file: ais_input_select_monitor.sv
// Purpose: assertions on bus and routing outputs of ais_input_select
// Assumes: one clock, synchronous active low reset
// Notes:   attached to every instance by the bind at the foot
`timescale 1ns/1ps
module ais_input_select_monitor
  import ais_pkg::*;
#(
  parameter logic [12:0] PRESENT_MASK = 13'h1fff
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // routing
  input wire logic        sample_done,
  input wire logic [4:0]  ch0_pos_input,
  input wire logic        ch0_pos_to_vref,
  input wire logic        ch0_pos_to_avss,
  input wire logic        ch123_enable,
  input wire logic        ch123_pos_upper,
  input wire logic [1:0]  ch123_neg_sel,
  input wire logic        sample_phase_b,
  input wire logic        resolution_12bit,
  input wire logic [12:0] pin_digital
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // bus handshake
  a_ack_one_cycle:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_follows_req:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_has_cause:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_upper_read_zero:
    assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper bits set");
  // ==========================================================
  // routing
  a_ch123_off_12bit:
    assert property (resolution_12bit |-> !ch123_enable) else $error("ch123 on in 12 bit");
  a_ch123_idle_zero:
    assert property (!ch123_enable |-> !ch123_pos_upper && ch123_neg_sel == 2'h0)
      else $error("ch123 routing while off");
  a_absent_to_vref:
    assert property (ch0_pos_to_vref == (ch0_pos_input > AIS_LAST_INPUT
      || !PRESENT_MASK[ch0_pos_input[3:0]])) else $error("vref select wrong");
  a_digital_to_avss:
    assert property (ch0_pos_to_avss == (!ch0_pos_to_vref
      && pin_digital[ch0_pos_input[3:0]])) else $error("avss select wrong");
  a_phase_b_cause:
    assert property ($rose(sample_phase_b) |-> $past(sample_done) || $past(sample_done, 2))
      else $error("phase b without sample");
  c_access: cover property (wb_ack_o);
  c_12bit: cover property (resolution_12bit);
  c_phase_b: cover property ($rose(sample_phase_b));
endmodule // ais_input_select_monitor

bind ais_input_select ais_input_select_monitor #(.PRESENT_MASK(PRESENT_MASK)) i_mon (
  .mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_done(sample_done),
  .ch0_pos_input(ch0_pos_input), .ch0_pos_to_vref(ch0_pos_to_vref),
  .ch0_pos_to_avss(ch0_pos_to_avss), .ch123_enable(ch123_enable),
  .ch123_pos_upper(ch123_pos_upper), .ch123_neg_sel(ch123_neg_sel),
  .sample_phase_b(sample_phase_b), .resolution_12bit(resolution_12bit),
  .pin_digital(pin_digital));

// file: tb_top.sv
// Purpose: self-checking bench for ais_input_select
// Assumes: default PRESENT_MASK, one cycle bus answer
// Notes:   random data from a fixed seed
`timescale 1ns/1ps
module tb_top
  import ais_pkg::*;
;
  logic        mclk, rstn, cyc, stb, we, sd, ack, nb, na;
  logic        vref, avss, an1, en, up, phb, res;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat, q, c, d;
  logic [4:0]  pin0, pa, pb, e;
  logic [1:0]  nsel;
  logic [12:0] pdig, m;
  logic [3:0]  ctl;
  int          failures, cmp_count, seed;

  // full variant: inputs 6-8 are legal selections here
  ais_input_select i_ais_input_select (
    .mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sample_done(sd), .ch0_pos_input(pin0), .ch0_pos_to_vref(vref),
    .ch0_pos_to_avss(avss), .ch0_neg_an1(an1), .ch123_enable(en),
    .ch123_pos_upper(up), .ch123_neg_sel(nsel), .sample_phase_b(phb),
    .resolution_12bit(res), .pin_digital(pdig));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================
  // checks and expectations
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("ERROR %0t read %h exp %h", $time, g, x);
    end
  endtask

  task automatic chk_out(input logic [15:0] g, input logic [15:0] x);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("ERROR %0t out %h exp %h", $time, g, x);
    end
  endtask

  function automatic logic [31:0] exp_rd(input logic [7:0] a, input logic [31:0] v,
                                         input logic r12);
    case (a)
      AIS_OFF_CH123: exp_rd = r12 ? 32'h0 : v & {16'h0, AIS_CH123_MASK};
      AIS_OFF_CTRL: exp_rd = v & {16'h0, AIS_CTRL_MASK};
      AIS_OFF_CH0: exp_rd = v & {16'h0, AIS_CH0_MASK};
      AIS_OFF_SCAN, AIS_OFF_PIN: exp_rd = v & {16'h0, AIS_INPUT_MASK};
      default: exp_rd = 32'h0;
    endcase
  endfunction

  // next set mask bit after c, wrapping past input 12
  function automatic logic [4:0] nxt(input logic [12:0] mk, input logic [4:0] c);
    nxt = c;
    for (int k = 13; k > 0; k--)
      if (mk[(c + k) % 13]) nxt = 5'((c + k) % 13);
  endfunction

  // ==========================================================
  // drivers
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= v;
    sel <= 4'hf;
    @(posedge mclk);
    while (ack !== 1'b1 && n < 16) begin
      @(posedge mclk);
      n++;
    end
    if (ack !== 1'b1) begin
      failures++;
      finish_test();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic pause();
    repeat (3) @(posedge mclk);
  endtask

  task automatic pulse();
    @(posedge mclk);
    sd <= 1'b1;
    @(posedge mclk);
    sd <= 1'b0;
    pause();
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
  endtask

  // ==========================================================
  // scenarios
  initial begin
    {cyc, stb, we, sd, adr, dat, ctl} = '0;
    sel = 4'hf;
    rstn = 1'b0;
    seed = 32'hf2df;
    do_reset();
    for (int a = 0; a < 24; a += 4) begin
      wb(1'b0, 8'(a), 32'h0);
      chk_rd(q, 32'h0);
    end
    // status is covered by the reset read; the last pass hits an unmapped word
    for (int i = 0; i < 24; i++) begin
      c = $random(seed);
      wb(1'b1, 8'((i % 5) * 4 + (i == 23 ? 16 : 0)), c);
      if (adr == AIS_OFF_CTRL) begin
        ctl = c[3:0];
      end
      wb(1'b0, adr, 32'h0);
      chk_rd(q, exp_rd(adr, c, ctl[0]));
    end
    $display("test register access done");
    for (int k = 0; k < 13; k++) begin
      c = $random(seed) & 32'h0707;
      pa = 5'(k);
      pb = 5'(k + 3);
      na = k[0];
      nb = ~k[0];
      // control first: a random twelve-bit setting would drop the ch1-3 write
      wb(1'b1, AIS_OFF_CTRL, 32'h0);
      wb(1'b1, AIS_OFF_CH123, c);
      wb(1'b1, AIS_OFF_CH0, {16'h0, nb, 2'h0, pb, na, 2'h0, pa});
      pause();
      chk_out(16'(pin0), 16'(pa));
      chk_out(16'(an1), 16'(na));
      chk_out(16'(up), 16'(c[0]));
      chk_out(16'(nsel), 16'(c[2:1]));
      wb(1'b1, AIS_OFF_CTRL, 32'h4);
      pulse();
      chk_out(16'(phb), 16'h1);
      chk_out(16'(pin0), 16'(pb));
      chk_out(16'(vref), 16'(pb > 5'h0c));
      chk_out(16'(an1), 16'(nb));
      chk_out(16'(up), 16'(c[8]));
      chk_out(16'(nsel), 16'(c[10:9]));
      pulse();
      chk_out(16'(phb), 16'h0);
    end
    $display("test routing done");
    wb(1'b1, AIS_OFF_CH123, 32'h0707);
    wb(1'b1, AIS_OFF_CTRL, 32'h1);
    wb(1'b1, AIS_OFF_CH123, 32'h0);
    wb(1'b0, AIS_OFF_CH123, 32'h0);
    chk_rd(q, 32'h0);
    chk_out(16'({en, res}), 16'h1);
    wb(1'b1, AIS_OFF_CTRL, 32'h0);
    wb(1'b0, AIS_OFF_CH123, 32'h0);
    chk_rd(q, 32'h0707);
    d = $random(seed);
    wb(1'b1, AIS_OFF_PIN, d);
    pause();
    chk_out(16'(pdig), 16'(d[12:0]));
    // ch0 positive still selects input 12 from the last routing pass
    chk_out(16'(avss), 16'(d[12]));
    wb(1'b1, AIS_OFF_CTRL, 32'h8);
    pause();
    chk_out(16'(pdig), 16'h1fff);
    chk_out(16'(avss), 16'h1);
    $display("test modes done");
    do_reset();
    m = 13'($random(seed)) | 13'h0004;
    wb(1'b1, AIS_OFF_SCAN, {19'h0, m});
    wb(1'b1, AIS_OFF_CTRL, 32'h2);
    pause();
    e = nxt(m, 5'h0c);
    for (int j = 0; j < 6; j++) begin
      chk_out(16'(pin0), 16'(e));
      pulse();
      e = nxt(m, e);
    end
    wb(1'b1, AIS_OFF_CTRL, 32'h0);
    pause();
    chk_out(16'(pin0), 16'h0);
    $display("test scan done");
    finish_test();
  end
endmodule // tb_top
